// File: logic/serial_port_status_flags.sv
// Status flags, control register and APB slave of the serial port.
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module serial_port_status_flags (
  input  wire logic        pclk,         // Core clock, 40 MHz.
  input  wire logic        presetn,      // Asynchronous reset, low.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB access phase.
  input  wire logic        pwrite,       // APB write.
  input  wire logic [11:0] paddr,        // APB byte address.
  input  wire logic [31:0] pwdata,       // APB write data.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error.
  input  wire logic        i2c_mode,     // Port runs as I2C when high.
  input  wire logic        start_det,    // START seen, one-cycle pulse.
  input  wire logic        stop_det,     // STOP seen, one-cycle pulse.
  input  wire logic        ack_det,      // Acknowledge bit, pulse.
  input  wire logic        addr_match,   // Address byte matched, pulse.
  input  wire logic        addr_rw,      // Read/write bit of address.
  input  wire logic        rx_done,      // Byte received, pulse.
  input  wire logic [7:0]  rx_byte,      // Received byte.
  input  wire logic        tx_mode,      // I2C transmit in progress.
  input  wire logic        tx_done,      // Byte shifted out, pulse.
  output logic             port_enable,  // Port enable bit.
  output logic             tx_load,      // Byte loaded to send, pulse.
  output logic      [7:0]  tx_byte,      // Byte handed to the shifter.
  output logic             irq           // Level interrupt.
);
  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire        acc      = psel && penable;
  wire        wr       = acc && pwrite;
  wire        rd       = acc && !pwrite;
  wire        hit_st   = (paddr == `ADDR_STATUS);
  wire        hit_ct   = (paddr == `ADDR_CONTROL);
  wire        hit_buf  = (paddr == `ADDR_BUFFER);
  wire        hit_is   = (paddr == `ADDR_IRQ_STATUS);
  wire        hit_im   = (paddr == `ADDR_IRQ_MASK);
  wire        mapped   = hit_st || hit_ct || hit_buf || hit_is || hit_im;
  wire        buf_rd   = rd && hit_buf;
  wire        buf_wr   = wr && hit_buf;
  // Strobes act in the access cycle only, so a buffer read or an
  // interrupt clear takes effect once per transfer even though the
  // answer itself is prepared during the setup cycle.

  logic [7:0]            control_reg;
  logic                  start_reg;
  logic                  stop_reg;
  logic                  dir_reg;
  logic                  full_reg;
  logic [`IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic [7:0]            buf_data;
  serial_port_pkg::bus_cond_t last_cond_reg;

  wire enabled = control_reg[`CT_PORT_ENABLE];

  // --------------------------------------------------------------------
  // Buffer storage
  // --------------------------------------------------------------------
  // Received bytes and bytes written by software share one holder,
  // as the port has one buffer for both directions.
  wire       hold_wr   = rx_done || buf_wr;
  wire [7:0] hold_data = rx_done ? rx_byte : pwdata[7:0];

  byte_holder #(.WIDTH(8)) u_holder (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (hold_wr),
    .wr_data (hold_data),
    .rd_data (buf_data)
  );

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `CONTROL_RESET;
    end else if (wr && hit_ct) begin
      control_reg <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------------
  // Bus condition flags
  // --------------------------------------------------------------------
  wire start_next = !enabled ? 1'b0 :
                    !i2c_mode ? 1'b0 :
                    start_det ? 1'b1 :
                    stop_det  ? 1'b0 : start_reg;
  wire stop_next  = !enabled || !i2c_mode ? 1'b0 :
                    stop_det  ? 1'b1 :
                    start_det ? 1'b0 : stop_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg     <= 1'b0;
      stop_reg      <= 1'b0;
      last_cond_reg <= serial_port_pkg::BUS_NONE;
    end else begin
      start_reg     <= start_next;
      stop_reg      <= stop_next;
      last_cond_reg <= start_next ? serial_port_pkg::BUS_START :
                       stop_next  ? serial_port_pkg::BUS_STOP :
                                    serial_port_pkg::BUS_NONE;
    end
  end

  // --------------------------------------------------------------------
  // Direction flag
  // --------------------------------------------------------------------
  // The flag keeps its value after a START, STOP or acknowledge; software
  // must not trust it outside the match-to-next-condition window.
  logic dir_valid_reg;
  wire  dir_end = start_det || stop_det || ack_det;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg       <= 1'b0;
      dir_valid_reg <= 1'b0;
    end else begin
      if (i2c_mode && addr_match) begin
        dir_reg <= addr_rw;
      end
      dir_valid_reg <= (i2c_mode && addr_match) ? 1'b1 :
                       dir_end ? 1'b0 : dir_valid_reg;
    end
  end

  // --------------------------------------------------------------------
  // Buffer-full flag
  // --------------------------------------------------------------------
  // A received byte is pending until software reads the buffer. In I2C
  // transmit the flag tracks the loaded byte until the shifter is done.
  wire tx_load_next = buf_wr && i2c_mode && tx_mode && enabled;
  wire full_next = rx_done      ? 1'b1 :
                   tx_load_next ? 1'b1 :
                   tx_done      ? 1'b0 :
                   buf_rd       ? 1'b0 : full_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_reg <= 1'b0;
      tx_load  <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      full_reg <= full_next;
      tx_load  <= tx_load_next;
      if (tx_load_next) begin
        tx_byte <= pwdata[7:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  wire [`IRQ_WIDTH-1:0] irq_events = {stop_det && i2c_mode,
                                      start_det && i2c_mode,
                                      tx_done, rx_done};
  wire [`IRQ_WIDTH-1:0] irq_clear  = (wr && hit_is) ?
                                     pwdata[`IRQ_WIDTH-1:0] : '0;
  // Set wins over a clear that lands in the same cycle.
  wire [`IRQ_WIDTH-1:0] irq_stat_next = irq_events |
                                        (irq_stat_reg & ~irq_clear);
  // The line is built from the next status and the next mask, so that it
  // never lags a mask write by a cycle and always matches what software
  // reads back from the two registers.
  wire [`IRQ_WIDTH-1:0] irq_mask_next = (wr && hit_im) ?
                                        pwdata[`IRQ_WIDTH-1:0] :
                                        irq_mask_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= `IRQ_MASK_RESET;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq          <= |(irq_stat_next & irq_mask_next);
    end
  end

  // --------------------------------------------------------------------
  // Read data and outputs
  // --------------------------------------------------------------------
  // The start and stop bits report which condition came last; when both
  // arrive in one cycle the start is taken as the later one.
  wire last_start = (last_cond_reg == serial_port_pkg::BUS_START);
  wire last_stop  = (last_cond_reg == serial_port_pkg::BUS_STOP);
  wire [7:0] status_val = {3'b000, last_stop, last_start, dir_reg,
                           1'b0, full_reg};
  wire [31:0] rd_mux =
    hit_st  ? {24'h00_0000, status_val} :
    hit_ct  ? {24'h00_0000, control_reg} :
    hit_buf ? {24'h00_0000, buf_data} :
    hit_is  ? {28'h000_0000, irq_stat_reg} :
    hit_im  ? {28'h000_0000, irq_mask_reg} : 32'h0000_0000;

  // Setup cycle loads the answer so that every access completes without a wait state.
  wire setup = psel && !penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      port_enable <= 1'b0;
    end else begin
      pready      <= setup;
      pslverr     <= setup && !mapped;
      prdata      <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      port_enable <= (wr && hit_ct) ? pwdata[`CT_PORT_ENABLE] : enabled;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_set: assert property (
    enabled && i2c_mode && start_det |=> start_reg)
    else $error("start flag not set after START");
  a_start_stop: assert property (
    i2c_mode && stop_det && !start_det |=> !start_reg)
    else $error("start flag not cleared by STOP");
  a_start_dis: assert property (
    !enabled |=> !start_reg)
    else $error("start flag set while port disabled");
  a_dir_capture: assert property (
    i2c_mode && addr_match |=> dir_reg == $past(addr_rw))
    else $error("direction flag did not capture rw bit");
  a_dir_window: assert property (
    dir_end && !(i2c_mode && addr_match) |=> !dir_valid_reg)
    else $error("direction window not closed");
  a_full_rx: assert property (
    rx_done |=> full_reg ##0 status_val[`ST_BUF_FULL])
    else $error("buffer full not set on reception");
  a_full_read: assert property (
    buf_rd && !rx_done && !tx_load_next |=> !full_reg)
    else $error("buffer full stays set after read");
  a_full_tx: assert property (
    tx_load_next ##1 (!tx_done && !buf_rd) |=> full_reg)
    else $error("buffer full dropped during transmit");
  a_full_txdone: assert property (
    tx_done && !rx_done && !tx_load_next |=> !full_reg)
    else $error("buffer full not cleared after transmit");
  a_irq_level: assert property (
    |(irq_stat_reg & irq_mask_reg) |-> irq)
    else $error("interrupt low with unmasked status");
  a_irq_quiet: assert property (
    !(|(irq_stat_reg & irq_mask_reg)) |-> !irq)
    else $error("interrupt high with nothing unmasked");
  a_ready_setup: assert property (
    setup |=> pready)
    else $error("ready missing after setup cycle");
  a_ready_only: assert property (
    !setup |=> !pready)
    else $error("ready raised without setup cycle");
  a_slverr_map: assert property (
    setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_read_idle: assert property (
    !(setup && !pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_port_enable: assert property (
    wr && hit_ct |=> port_enable == $past(pwdata[`CT_PORT_ENABLE]))
    else $error("port enable output does not follow control");
  a_tx_load: assert property (
    tx_load_next |=> tx_load && tx_byte == $past(pwdata[7:0]))
    else $error("transmit load pulse or byte wrong");

  c_start: cover property (start_det ##[1:20] addr_match);
  c_rx_read: cover property (rx_done ##[1:10] buf_rd);
  c_tx: cover property (tx_load_next ##[1:50] tx_done);
  c_irq: cover property ($rose(irq));
  c_dir: cover property (addr_match ##[1:20] ack_det);
endmodule

// File: logic/serial_port_defs.svh
// Constants for the serial port status flag block.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_STATUS       12'h000
`define ADDR_CONTROL      12'h004
`define ADDR_BUFFER       12'h008
`define ADDR_IRQ_STATUS   12'h00C
`define ADDR_IRQ_MASK     12'h010
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ST_BUF_FULL       0
`define ST_ADDR_UPDATE    1
`define ST_DIRECTION      2
`define ST_START_SEEN     3
`define ST_STOP_SEEN      4
`define CT_PORT_ENABLE    5
`define CT_CLOCK_POL      4
`define IRQ_RX_DONE       0
`define IRQ_TX_DONE       1
`define IRQ_START         2
`define IRQ_STOP          3
`define IRQ_WIDTH         4
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CONTROL_RESET     8'h00
`define IRQ_MASK_RESET    4'h0
`endif

// File: logic/serial_port_pkg.sv
// Types shared by the serial port status flag block.
package serial_port_pkg;
  typedef enum logic [1:0] {
    BUS_NONE,
    BUS_START,
    BUS_STOP
  } bus_cond_t;
endpackage

// File: logic/byte_holder.sv
// Single-word buffer register for the serial shift buffer.
`timescale 1ns/1ps
module byte_holder #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,     // Core clock.
  input  wire logic             presetn,  // Asynchronous reset, low.
  input  wire logic             wr_en,    // Load strobe.
  input  wire logic [WIDTH-1:0] wr_data,  // Word to store.
  output logic      [WIDTH-1:0] rd_data   // Stored word, registered.
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule

// File: bench/bus_master_model.sv
// Behavioural far-side bus controller that reports bus events as pulses.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic       pclk,        // Core clock.
  output logic            start_det,   // START event pulse.
  output logic            stop_det,    // STOP event pulse.
  output logic            ack_det,     // Acknowledge pulse.
  output logic            addr_match,  // Address match pulse.
  output logic            addr_rw,     // Read/write bit of address.
  output logic            rx_done,     // Byte received pulse.
  output logic      [7:0] rx_byte,     // Received byte.
  output logic            tx_done      // Byte shifted out pulse.
);
  initial begin
    {start_det, stop_det, ack_det, addr_match, rx_done, tx_done} = 6'h00;
    addr_rw = 1'b0;
    rx_byte = 8'h00;
  end
  // Kind: 0 start, 1 stop, 2 ack, 3 address, 4 receive, other transmit done.
  task automatic fire(input logic [2:0] kind, input logic [7:0] data);
    @(posedge pclk);
    case (kind)
      3'd0: start_det <= 1'b1;
      3'd1: stop_det <= 1'b1;
      3'd2: ack_det <= 1'b1;
      3'd3: begin
        addr_match <= 1'b1;
        addr_rw    <= data[0];
      end
      3'd4: begin
        rx_done <= 1'b1;
        rx_byte <= data;
      end
      default: tx_done <= 1'b1;
    endcase
    @(posedge pclk);
    {start_det, stop_det, ack_det, addr_match, rx_done, tx_done} <= 6'h00;
    // Data is only held with its strobe, so it turns over afterwards.
    rx_byte <= ~data;
    addr_rw <= ~data[0];
  endtask
endmodule

// File: bench/serial_port_status_flags_tb_top.sv
// Self-checking bench for the serial port status flag block.
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module serial_port_status_flags_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, i2c_mode, tx_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, port_enable, tx_load, irq, er;
  logic [7:0]  tx_byte, rx_byte;
  logic        start_det, stop_det, ack_det, addr_match, addr_rw;
  logic        rx_done, tx_done;
  int          err_count = 0;
  int          tests_run = 0;

  always #12.5 pclk = ~pclk;

  serial_port_status_flags DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i2c_mode(i2c_mode),
    .start_det(start_det), .stop_det(stop_det), .ack_det(ack_det),
    .addr_match(addr_match), .addr_rw(addr_rw), .rx_done(rx_done),
    .rx_byte(rx_byte), .tx_mode(tx_mode), .tx_done(tx_done),
    .port_enable(port_enable), .tx_load(tx_load), .tx_byte(tx_byte),
    .irq(irq));

  bus_master_model pm (
    .pclk(pclk), .start_det(start_det), .stop_det(stop_det),
    .ack_det(ack_det), .addr_match(addr_match), .addr_rw(addr_rw),
    .rx_done(rx_done), .rx_byte(rx_byte), .tx_done(tx_done));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Waits on pready itself, since the slave's latency is its own business.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      $display("BAD %0t no ready", $time);
      end_of_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task bit_is(input int pos, input logic exp);
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, rd[pos]}, {31'h0, exp});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, `ADDR_IRQ_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `ADDR_CONTROL, 32'hFFFF_FFFF);
    apb(1'b0, `ADDR_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    apb(1'b1, 12'h0FC, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset and map done");
  endtask

  task t_start;
    i2c_mode <= 1'b1;
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0020);
    @(posedge pclk);
    chk({31'h0, port_enable}, 32'h0000_0001);
    pm.fire(3'd0, 8'h00);
    bit_is(`ST_START_SEEN, 1'b1);
    pm.fire(3'd1, 8'h00);
    bit_is(`ST_START_SEEN, 1'b0);
    pm.fire(3'd0, 8'h00);
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0000);
    bit_is(`ST_START_SEEN, 1'b0);
    chk({31'h0, port_enable}, 32'h0000_0000);
    pm.fire(3'd0, 8'h00);
    bit_is(`ST_START_SEEN, 1'b0);
    $display("test start flag done");
  endtask

  task t_dir;
    apb(1'b1, `ADDR_CONTROL, 32'h0000_0020);
    pm.fire(3'd3, 8'h01);
    bit_is(`ST_DIRECTION, 1'b1);
    pm.fire(3'd3, 8'h00);
    bit_is(`ST_DIRECTION, 1'b0);
    pm.fire(3'd2, 8'h00);
    $display("test direction done");
  endtask

  task t_rx;
    for (int m = 0; m < 2; m++) begin
      i2c_mode <= m[0];
      apb(1'b1, `ADDR_IRQ_MASK, {31'h0, m[0]});
      pm.fire(3'd4, 8'h3C ^ 8'(m));
      bit_is(`ST_BUF_FULL, 1'b1);
      chk({31'h0, irq}, {31'h0, m[0]});
      apb(1'b0, `ADDR_BUFFER, 32'h0000_0000);
      chk(rd, {24'h0, 8'h3C ^ 8'(m)});
      bit_is(`ST_BUF_FULL, 1'b0);
      apb(1'b1, `ADDR_IRQ_STATUS, 32'h0000_0001);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
      // Start and stop events of the start scenario stay pending.
      chk(rd, 32'h0000_000C);
    end
    $display("test receive done");
  endtask

  task t_tx;
    int n;
    i2c_mode <= 1'b1;
    tx_mode  <= 1'b1;
    apb(1'b1, `ADDR_BUFFER, 32'h0000_00A5);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_load !== 1'b1 && n < 5);
    chk({31'h0, tx_load}, 32'h0000_0001);
    chk({24'h0, tx_byte}, 32'h0000_00A5);
    bit_is(`ST_BUF_FULL, 1'b1);
    pm.fire(3'd5, 8'h00);
    bit_is(`ST_BUF_FULL, 1'b0);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000);
    chk({31'h0, rd[`IRQ_TX_DONE]}, 32'h0000_0001);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0002);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test transmit done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, i2c_mode, tx_mode} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_start();
    t_dir();
    t_rx();
    t_tx();
    end_of_test();
  end
endmodule
